// File: rtl/term_regs_defs.vh
// Register map and field positions of the terminal configuration bank
`ifndef TERM_REGS_DEFS_VH
`define TERM_REGS_DEFS_VH
`define ADDR_CFG_ONE 5'h01
`define ADDR_CFG_TWO 5'h02
`define ADDR_MSG_CTRL 5'h04
`define ADDR_STAMP 5'h05
`define MODE_HI 15
`define MODE_LO 14
`define MODE_BC 2'h0
`define MODE_RT 2'h2
`define MODE_MT 2'h1
`define CFG1_STAT_W 3
`define CFG1_ALT_HI 11
`define CFG1_MMT_BIT 12
`define CFG2_ZERO_BIT 14
`define CFG2_DBUF_BIT 12
`define CFG2_RATE_HI 9
`define CFG2_RATE_LO 7
`define CFG2_AUTOCLR_BIT 4
`define CFG2_PULSE_BIT 3
`define CTRL_MASK_HI 14
`define CTRL_MASK_LO 9
`define CTRL_BCST_MASK_BIT 5
`define CTRL_RETRY_BIT 8
`define CTRL_CHAN_BIT 7
`define CTRL_EOM_IRQ_BIT 4
`define CTRL_STD_BIT 3
`define CTRL_MODE_CODE_BIT 2
`define CTRL_BCST_BIT 1
`define CTRL_RTRT_BIT 0
`define RESET_WORD 16'h0000
`define RATE_W 3
`define RATE_PRESCALE_BASE 16'h0001
`endif

// File: rtl/stamp_counter.v
// Time stamp counter with selectable tick rate
`timescale 1ns/1ps
`include "term_regs_defs.vh"
module stamp_counter #(
    parameter WIDTH = 16
) (
    clk,
    srst,
    rate_sel,
    load_en,
    load_val,
    count
);
    input wire clk;
    input wire srst;
    input wire [`RATE_W-1:0] rate_sel;
    input wire load_en;
    input wire [WIDTH-1:0] load_val;
    output wire [WIDTH-1:0] count;

    reg [WIDTH-1:0] count_ff;
    reg [15:0] pre_ff;
    wire [15:0] limit;

    // Divider doubles per step; rate 0 ticks every cycle
    assign limit = (`RATE_PRESCALE_BASE << rate_sel) - 16'h0001;
    assign count = count_ff;

    always @(posedge clk) begin
        if (srst) begin
            pre_ff <= 16'h0000;
            count_ff <= {WIDTH{1'b0}};
        end else if (load_en) begin
            pre_ff <= 16'h0000;
            count_ff <= load_val;
        end else if (pre_ff >= limit) begin
            pre_ff <= 16'h0000;
            count_ff <= count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
        end else begin
            pre_ff <= pre_ff + 16'h0001;
        end
    end
endmodule // stamp_counter

// File: rtl/bus_terminal_config_regs.v
// Terminal configuration, message control and time stamp registers
`timescale 1ns/1ps
`include "term_regs_defs.vh"
// Overview of operation
// - Bits 15:14 of config one pick controller (00), remote terminal (10) or monitor (01).
// - Bits 2:0 of config one read back live activity status in controller and monitor mode.
// - In remote terminal mode with alternate status, bits 11:0 of config one form the status word.
// - Bit 14 of config two always reads zero whatever is written.
// - Bits 9:7 of config two select the time stamp counter rate.
// - Control word bits 14:9 and 5 are the status and broadcast mask bits.
// - Control word bits 0-4, 7 and 8 give each message's format options.
// - Config two bit 3 picks level or pulse interrupt, bit 4 enables status auto-clear.
module bus_terminal_config_regs #(
    parameter DW = 16,
    parameter AW = 5
) (
    clk,
    srst,
    addr,
    wr_en,
    rd_en,
    wr_data,
    rd_data,
    alt_status_sel,
    rt_msg_active,
    bc_enabled,
    bc_frame_active,
    bc_msg_active,
    mt_enabled,
    mt_triggered,
    mt_active,
    bus_controller_mode,
    remote_terminal_mode,
    monitor_terminal_mode,
    message_monitor_enable,
    alt_status_word,
    alt_status_valid,
    rx_double_buffer,
    stamp_rate,
    irq_pulse_mode,
    irq_auto_clear,
    status_masks,
    broadcast_mask,
    msg_rt_to_rt,
    msg_broadcast,
    msg_mode_code,
    msg_std_select,
    end_of_transfer_irq_en,
    msg_channel_b,
    msg_retry_en,
    time_stamp
);
    input wire clk;
    input wire srst;
    input wire [AW-1:0] addr;
    input wire wr_en;
    input wire rd_en;
    input wire [DW-1:0] wr_data;
    output wire [DW-1:0] rd_data;
    input wire alt_status_sel;
    input wire rt_msg_active;
    input wire bc_enabled;
    input wire bc_frame_active;
    input wire bc_msg_active;
    input wire mt_enabled;
    input wire mt_triggered;
    input wire mt_active;
    output wire bus_controller_mode;
    output wire remote_terminal_mode;
    output wire monitor_terminal_mode;
    output wire message_monitor_enable;
    output wire [`CFG1_ALT_HI:0] alt_status_word;
    output wire alt_status_valid;
    output wire rx_double_buffer;
    output wire [`RATE_W-1:0] stamp_rate;
    output wire irq_pulse_mode;
    output wire irq_auto_clear;
    output wire [`CTRL_MASK_HI-`CTRL_MASK_LO:0] status_masks;
    output wire broadcast_mask;
    output wire msg_rt_to_rt;
    output wire msg_broadcast;
    output wire msg_mode_code;
    output wire msg_std_select;
    output wire end_of_transfer_irq_en;
    output wire msg_channel_b;
    output wire msg_retry_en;
    output wire [DW-1:0] time_stamp;

    reg [DW-1:0] cfg_one_ff;
    reg [DW-1:0] cfg_two_ff;
    reg [DW-1:0] msg_ctrl_ff;
    reg [2:0] live_stat;
    reg [DW-1:0] nxt_rd_data;
    reg [DW-1:0] nxt_cfg_one;
    reg [DW-1:0] nxt_cfg_two;
    reg [DW-1:0] nxt_msg_ctrl;
    reg [DW-1:0] rd_data_ff;
    wire [1:0] mode;
    wire [DW-1:0] cfg_one_view;
    wire stamp_load;

    // Mode 11 is undefined and decodes to no mode
    assign mode = {cfg_one_ff[`MODE_HI], cfg_one_ff[`MODE_LO]};
    assign bus_controller_mode = (mode == `MODE_BC);
    assign remote_terminal_mode = (mode == `MODE_RT);
    assign monitor_terminal_mode = (mode == `MODE_MT);
    assign message_monitor_enable = cfg_one_ff[`CFG1_MMT_BIT];

    // Alternate status word is bits 11:0; bit 0 still reads back live
    assign alt_status_valid = remote_terminal_mode & alt_status_sel;
    assign alt_status_word = cfg_one_ff[`CFG1_ALT_HI:0];

    always @* begin
        live_stat = 3'h0;
        if (bus_controller_mode) begin
            live_stat = {bc_enabled, bc_frame_active, bc_msg_active};
        end else if (monitor_terminal_mode) begin
            live_stat = {mt_enabled, mt_triggered, mt_active};
        end else if (remote_terminal_mode) begin
            live_stat[0] = rt_msg_active;
            if (alt_status_sel) begin
                live_stat[`CFG1_STAT_W-1:1] = cfg_one_ff[`CFG1_STAT_W-1:1];
            end
        end else begin
            // Mode 11 echoes the stored bits
            live_stat = cfg_one_ff[`CFG1_STAT_W-1:0];
        end
    end
    assign cfg_one_view = {cfg_one_ff[DW-1:`CFG1_STAT_W], live_stat};

    assign rx_double_buffer = remote_terminal_mode & cfg_two_ff[`CFG2_DBUF_BIT];
    assign stamp_rate = cfg_two_ff[`CFG2_RATE_HI:`CFG2_RATE_LO];
    assign irq_pulse_mode = cfg_two_ff[`CFG2_PULSE_BIT];
    assign irq_auto_clear = cfg_two_ff[`CFG2_AUTOCLR_BIT];

    assign status_masks = msg_ctrl_ff[`CTRL_MASK_HI:`CTRL_MASK_LO];
    assign broadcast_mask = msg_ctrl_ff[`CTRL_BCST_MASK_BIT];
    assign msg_rt_to_rt = msg_ctrl_ff[`CTRL_RTRT_BIT];
    assign msg_broadcast = msg_ctrl_ff[`CTRL_BCST_BIT];
    assign msg_mode_code = msg_ctrl_ff[`CTRL_MODE_CODE_BIT];
    assign msg_std_select = msg_ctrl_ff[`CTRL_STD_BIT];
    assign end_of_transfer_irq_en = msg_ctrl_ff[`CTRL_EOM_IRQ_BIT];
    assign msg_channel_b = msg_ctrl_ff[`CTRL_CHAN_BIT];
    assign msg_retry_en = msg_ctrl_ff[`CTRL_RETRY_BIT];

    // Loading the stamp also restarts its prescaler
    assign stamp_load = wr_en && (addr == `ADDR_STAMP);

    // Next values; bit 14 of config two is never stored
    always @* begin
        nxt_cfg_one = cfg_one_ff;
        nxt_cfg_two = cfg_two_ff;
        nxt_msg_ctrl = msg_ctrl_ff;
        if (wr_en) begin
            case (addr)
                `ADDR_CFG_ONE: begin
                    nxt_cfg_one = wr_data;
                end
                `ADDR_CFG_TWO: begin
                    nxt_cfg_two = wr_data;
                    nxt_cfg_two[`CFG2_ZERO_BIT] = 1'b0;
                end
                `ADDR_MSG_CTRL: begin
                    nxt_msg_ctrl = wr_data;
                end
                default: begin
                    nxt_cfg_one = cfg_one_ff;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            cfg_one_ff <= `RESET_WORD;
            cfg_two_ff <= `RESET_WORD;
            msg_ctrl_ff <= `RESET_WORD;
        end else begin
            cfg_one_ff <= nxt_cfg_one;
            cfg_two_ff <= nxt_cfg_two;
            msg_ctrl_ff <= nxt_msg_ctrl;
        end
    end

    // Unmapped addresses read zero
    // A read in the write cycle returns the old value
    always @* begin
        nxt_rd_data = {DW{1'b0}};
        case (addr)
            `ADDR_CFG_ONE: nxt_rd_data = cfg_one_view;
            `ADDR_CFG_TWO: nxt_rd_data = cfg_two_ff;
            `ADDR_MSG_CTRL: nxt_rd_data = msg_ctrl_ff;
            `ADDR_STAMP: nxt_rd_data = time_stamp;
            default: nxt_rd_data = {DW{1'b0}};
        endcase
    end

    // Read data registered one cycle after rd_en; holds otherwise
    always @(posedge clk) begin
        if (srst) begin
            rd_data_ff <= `RESET_WORD;
        end else if (rd_en) begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data = rd_data_ff;

    stamp_counter #(
        .WIDTH(DW)
    ) u_stamp (
        .clk(clk),
        .srst(srst),
        .rate_sel(stamp_rate),
        .load_en(stamp_load),
        .load_val(wr_data),
        .count(time_stamp)
    );
endmodule // bus_terminal_config_regs

// File: dv/term_regs_sva.sv
// Port assertions for the terminal configuration registers
`timescale 1ns/1ps
module term_regs_sva (
    input wire logic clk, srst, wr_en, rd_en, bc_enabled, bc_frame_active, bc_msg_active,
    input wire logic rt_msg_active, mt_enabled, mt_triggered, mt_active,
    input wire logic bus_controller_mode, remote_terminal_mode, monitor_terminal_mode,
    input wire logic rx_double_buffer, irq_pulse_mode, irq_auto_clear, broadcast_mask,
    input wire logic msg_rt_to_rt, msg_broadcast, msg_mode_code, msg_std_select,
    input wire logic end_of_transfer_irq_en, msg_channel_b, msg_retry_en,
    input wire logic [4:0] addr,
    input wire logic [15:0] wr_data, rd_data,
    input wire logic [5:0] status_masks,
    input wire logic [2:0] stamp_rate
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_wr(a);
        wr_en && addr == a;
    endsequence
    sequence s_rd(a);
        rd_en && !wr_en && addr == a;
    endsequence
    a_monitor_status: assert property (s_rd(5'h01) ##0 monitor_terminal_mode |=>
        rd_data[2:0] == {$past(mt_enabled), $past(mt_triggered), $past(mt_active)})
        else $error("monitor status");
    a_rt_busy_bit: assert property (s_rd(5'h01) ##0 remote_terminal_mode |=>
        rd_data[0] == $past(rt_msg_active)) else $error("rt busy bit");
    // Mode 11 is left out: its decode is undefined
    a_mode_decode: assert property (s_wr(5'h01) ##0 !(&wr_data[15:14]) |=>
        {remote_terminal_mode, monitor_terminal_mode} == $past(wr_data[15:14])
        && bus_controller_mode == ($past(wr_data[15:14]) == 2'h0)) else $error("mode decode");
    a_live_status: assert property (rd_en && !wr_en && addr == 5'h01 && bus_controller_mode |=>
        rd_data[2:0] == {$past(bc_enabled), $past(bc_frame_active), $past(bc_msg_active)})
        else $error("live status");
    a_bit14_zero: assert property (rd_en && addr == 5'h02 |=> !rd_data[14])
        else $error("bit 14 set");
    a_rate_field: assert property (s_wr(5'h02) |=> stamp_rate == $past(wr_data[9:7])
        && {irq_auto_clear, irq_pulse_mode} == $past(wr_data[4:3])) else $error("rate or irq");
    a_dbuf_rt: assert property (s_wr(5'h02) |=>
        rx_double_buffer == ($past(wr_data[12]) && remote_terminal_mode)) else $error("dbuf");
    a_mask_bits: assert property (s_wr(5'h04) |=> status_masks == $past(wr_data[14:9])
        && broadcast_mask == $past(wr_data[5])) else $error("masks");
    a_ctrl_format: assert property (s_wr(5'h04) |=>
        {msg_retry_en, msg_channel_b, end_of_transfer_irq_en, msg_std_select, msg_mode_code,
        msg_broadcast, msg_rt_to_rt} == {$past(wr_data[8]), $past(wr_data[7]), $past(wr_data[4:0])})
        else $error("format bits");
    a_unmapped_keep: assert property (s_wr(5'h03) |=> $stable(status_masks)
        && $stable(stamp_rate)) else $error("unmapped write");
endmodule // term_regs_sva
bind bus_terminal_config_regs term_regs_sva u_sva (.*);

// File: dv/host_port.sv
// Host processor model on the parallel register port
`timescale 1ns/1ps
module host_port (
    input wire logic clk,
    input wire logic [15:0] rd_data,
    output logic [4:0] addr,
    output logic wr_en, rd_en,
    output logic [15:0] wr_data
);
    initial begin
        {addr, wr_en, rd_en, wr_data} = 23'h0;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        wr_data = ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        d = rd_data;
    endtask
endmodule // host_port

// File: dv/bus_terminal_config_regs_bench.sv
// Self-checking bench for the terminal configuration registers
`timescale 1ns/1ps
module bus_terminal_config_regs_bench;
    logic clk, srst, wr_en, rd_en, alt_status_sel, rt_msg_active, bc_enabled, bc_frame_active;
    logic bc_msg_active, mt_enabled, mt_triggered, mt_active, bus_controller_mode, msg_retry_en;
    logic remote_terminal_mode, monitor_terminal_mode, message_monitor_enable, alt_status_valid;
    logic rx_double_buffer, irq_pulse_mode, irq_auto_clear, broadcast_mask, msg_rt_to_rt;
    logic msg_broadcast, msg_mode_code, msg_std_select, end_of_transfer_irq_en, msg_channel_b;
    logic [2:0] stamp_rate;
    logic [4:0] addr;
    logic [5:0] status_masks;
    logic [11:0] alt_status_word;
    logic [15:0] wr_data, rd_data, time_stamp, got;
    int miscompares, n_compared, cycles, n;
    wire [2:0] mode_vec = {bus_controller_mode, remote_terminal_mode, monitor_terminal_mode};
    localparam logic [39:0] ROWS [6] = '{
        40'h02_FFFF_BFFF,
        40'h02_0380_0380,
        40'h04_FFFF_FFFF,
        40'h04_0000_0000,
        40'h01_4007_4000,
        40'h01_1FF8_1FF8};
    host_port u_host (.clk, .rd_data, .addr, .wr_en, .rd_en, .wr_data);
    bus_terminal_config_regs u_dut (.clk, .srst, .addr, .wr_en, .rd_en, .wr_data, .rd_data,
        .alt_status_sel, .rt_msg_active, .bc_enabled, .bc_frame_active, .bc_msg_active,
        .mt_enabled, .mt_triggered, .mt_active, .bus_controller_mode, .remote_terminal_mode,
        .monitor_terminal_mode, .message_monitor_enable, .alt_status_word, .alt_status_valid,
        .rx_double_buffer, .stamp_rate, .irq_pulse_mode, .irq_auto_clear, .status_masks,
        .broadcast_mask, .msg_rt_to_rt, .msg_broadcast, .msg_mode_code, .msg_std_select,
        .end_of_transfer_irq_en, .msg_channel_b, .msg_retry_en, .time_stamp);
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_rd(input logic [4:0] a, input logic [15:0] e);
        u_host.rd(a, got);
        chk(got, e);
    endtask
    task automatic end_of_test;
        $display("compared %0d, miscompared %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Whole run needs under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        srst = 1'b1;
        {alt_status_sel, rt_msg_active, bc_enabled, bc_frame_active} = 4'h0;
        {bc_msg_active, mt_enabled, mt_triggered, mt_active} = 4'h0;
        repeat (6) @(negedge clk);
        srst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            u_host.wr(ROWS[i][36:32], ROWS[i][31:16]);
            chk_rd(ROWS[i][36:32], ROWS[i][15:0]);
        end
        {rt_msg_active, bc_enabled, bc_frame_active, bc_msg_active} = 4'hD;
        {mt_enabled, mt_triggered, mt_active} = 3'h6;
        for (int m = 0; m < 3; m++) begin
            u_host.wr(5'h01, {m[1:0], 14'h0000});
            chk(mode_vec, {m == 0, m == 2, m == 1});
            n = (m == 2) ? 1 : ((m == 0) ? 5 : 6);
            chk_rd(5'h01, {m[1:0], 11'h000, n[2:0]});
        end
        alt_status_sel = 1'b1;
        u_host.wr(5'h01, 16'h8ABC);
        chk({alt_status_valid, alt_status_word}, 16'h1ABC);
        chk_rd(5'h01, 16'h8ABD);
        u_host.wr(5'h02, 16'h1298);
        chk({rx_double_buffer, stamp_rate, irq_auto_clear, irq_pulse_mode}, 16'h0037);
        u_host.wr(5'h01, 16'h1000);
        chk({rx_double_buffer, message_monitor_enable}, 16'h0001);
        for (int r = 0; r < 8; r += 3) begin
            u_host.wr(5'h02, {6'h00, r[2:0], 7'h00});
            u_host.wr(5'h05, 16'h1000);
            for (n = 0; n < 300 && time_stamp == 16'h1000; n++) @(negedge clk);
            for (n = 0; n < 300 && time_stamp == 16'h1001; n++) @(negedge clk);
            chk(n, 1 << r);
            chk(time_stamp, 16'h1002);
        end
        u_host.wr(5'h03, 16'hFFFF);
        u_host.wr(5'h1F, 16'hFFFF);
        chk_rd(5'h02, 16'h0300);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk(mode_vec, 16'h0004);
        chk_rd(5'h04, 16'h0000);
        end_of_test();
    end
endmodule // bus_terminal_config_regs_bench
